// *** mtmr_chk.sv ***
// Bus, period and code flag checker for the track measurement reporter
`timescale 1ns/1ns
module mtmr_chk #(
  parameter int PERIOD_CYCLES = 64
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Status
  input wire logic code_avail_o,
  input wire logic period_tick_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic take;
  logic rd_code;
  logic rd_stat;
  logic seen_reg;
  int cnt_reg;
  // Request decode, a held request is not taken again while acked
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign rd_code = take && !wb_we_i && wb_adr_i[7:2] == mtmr_pkg::ADR_CODE[7:2];
  assign rd_stat = take && !wb_we_i && wb_adr_i[7:2] == mtmr_pkg::ADR_STATUS[7:2];
  // Cycles since last tick; first period after reset is skipped
  always_ff @(posedge clk_i) begin
    if (rst_i || period_tick_o) begin
      cnt_reg <= 0;
    end else begin
      cnt_reg <= cnt_reg + 1;
    end
  end
  // Set once a tick was seen
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seen_reg <= 1'b0;
    end else if (period_tick_o) begin
      seen_reg <= 1'b1;
    end
  end
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_latency_a: assert property (take |=> wb_ack_o)
    else $error("ack missing after request");
  ack_cause_a: assert property (wb_ack_o |-> $past(take))
    else $error("ack without request");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  tick_pulse_a: assert property (period_tick_o |=> !period_tick_o)
    else $error("tick wider than one cycle");
  tick_spacing_a: assert property (seen_reg |-> (period_tick_o == (cnt_reg == PERIOD_CYCLES - 1)))
    else $error("tick spacing wrong");
  flag_rise_a: assert property ($rose(code_avail_o) |-> $past(period_tick_o, 2))
    else $error("code flag rose off the decode slot");
  flag_clear_a: assert property ($fell(code_avail_o) |-> $past(rd_code))
    else $error("code flag cleared without code read");
  status_flag_a: assert property (wb_ack_o && $past(rd_stat) |-> wb_dat_o[0] == $past(code_avail_o))
    else $error("status flag bit differs from flag");
  cover property ($rose(code_avail_o));
  cover property (rd_code && code_avail_o);
  cover property (seen_reg && period_tick_o);
endmodule

bind mtmr_reporter mtmr_chk #(.PERIOD_CYCLES(PERIOD_CYCLES)) i_mtmr_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .code_avail_o, .period_tick_o);

// *** mtmr_host.sv ***
// Navigation computer model: classic Wishbone master reading reports
`timescale 1ns/1ns
module mtmr_host (
  // Clock
  input wire logic clk_i,
  // Wishbone master
  output logic wb_cyc_o,
  output logic wb_stb_o,
  output logic wb_we_o,
  output logic [7:0] wb_adr_o,
  output logic [3:0] wb_sel_o,
  output logic [31:0] wb_dat_o,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_i
);
  // Idle bus at time zero
  initial begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o = 1'b0;
    wb_adr_o = 8'h0;
    wb_sel_o = 4'h0;
    wb_dat_o = 32'h0;
  end
  // One cycle, held until ack; only the bench watchdog ends a dead wait
  task automatic xfer(input logic we, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o <= we;
    wb_adr_o <= a;
    wb_sel_o <= s;
    wb_dat_o <= d;
    do begin
      @(posedge clk_i);
    end while (wb_ack_i !== 1'b1);
    // Data taken at the very edge that shows ack
    q = wb_dat_i;
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, s, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 4'hf, 32'h0, q);
  endtask
  task automatic follow(input logic right, output logic [31:0] q);
    rd(right ? mtmr_pkg::ADR_TRACK_R : mtmr_pkg::ADR_TRACK_L, q);
  endtask
  task automatic fetch_code(input logic flag, output logic [31:0] q);
    q = 32'h0;
    if (flag === 1'b1) begin
      rd(mtmr_pkg::ADR_CODE, q);
    end
  endtask
endmodule

// *** mtmr_pkg.sv ***
// Constants, register map and types of the magnetic track measurement reporter
// What this block does
// - Evaluate a complete new measurement set every 5 ms, a 200 Hz rate.
// - Every report carries a left and a right track data set.
// - With exactly one track, left and right sets hold identical values.
// - Two-bit strength code per track: 00 none, 01 weak, 10 medium, 11 strong.
// - Any non-zero strength is a valid track with position and angle reported.
// - Lateral position is signed millimetres from centre, negative left, positive right.
// - Each track's incidence angle is reported separately in one-degree steps.
// - A second track fills the other set; with one track both sets match again.
// - Opposite-polarity zones are markers, reported separately for left and right side.
// - The first detected marker on each side also has its lateral position reported.
// - Code decoding starts once a left or right marker appears.
// - Decoding runs while any marker is present, and captures when none remain after a both-sided closing run.
// - Codes are one to sixteen bits, built from concatenated base patterns.
// - A recognised code sets a code-available status flag and holds the value.
// - Point-source magnets are found on the marker path with X and Y reported.
// - Tracks are raised field zones, markers lowered field zones against zero level.
// - Track polarity is selectable; default north-up tracks, inverted setting swaps both.
package mtmr_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned PERIOD_US = 5000;
  localparam int unsigned PERIOD_CYC = (CLK_HZ / 1_000_000) * PERIOD_US;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_THR_DET = 8'h04;
  localparam logic [7:0] ADR_THR_STR = 8'h08;
  localparam logic [7:0] ADR_STATUS = 8'h0c;
  localparam logic [7:0] ADR_TRACK_L = 8'h10;
  localparam logic [7:0] ADR_TRACK_R = 8'h14;
  localparam logic [7:0] ADR_MARKERS = 8'h18;
  localparam logic [7:0] ADR_POINT = 8'h1c;
  localparam logic [7:0] ADR_CODE = 8'h20;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic RST_POL_INV = 1'b0;
  localparam logic [15:0] RST_TRACK_THR = 16'h0100;
  localparam logic [15:0] RST_MARK_THR = 16'h0100;
  localparam logic [15:0] RST_MED_THR = 16'h0400;
  localparam logic [15:0] RST_STRONG_THR = 16'h0800;

  // ----------------------------------------
  // Encodings
  // ----------------------------------------
  localparam logic [1:0] STR_NONE = 2'b00;
  localparam logic [1:0] STR_WEAK = 2'b01;
  localparam logic [1:0] STR_MED = 2'b10;
  localparam logic [1:0] STR_STRONG = 2'b11;
  localparam logic [1:0] KIND_NONE = 2'b00;
  localparam logic [1:0] KIND_TRACK = 2'b01;
  localparam logic [1:0] KIND_MARK = 2'b10;
  localparam logic [4:0] CODE_MAX_BITS = 5'h10;
  localparam logic [1:0] SLOTS = 2'h2;

  typedef enum logic [1:0] {
    DEC_IDLE = 2'b00,
    DEC_SIDE = 2'b01,
    DEC_BOTH = 2'b10,
    DEC_FAIL = 2'b11
  } mtmr_dec_type;

endpackage

// *** mtmr_reporter.sv ***
// Magnetic track measurement reporter with Wishbone register slave
`timescale 1ns/1ns
module mtmr_reporter #(
  parameter int PERIOD_CYCLES = mtmr_pkg::PERIOD_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Detector front end, one field peak per pulse
  input wire logic meas_valid_i,
  input wire logic signed [15:0] meas_amp_i,
  input wire logic signed [7:0] meas_x_i,
  input wire logic signed [7:0] meas_ang_i,
  input wire logic signed [7:0] meas_y_i,
  // Status
  output logic code_avail_o,
  output logic period_tick_o
);

  localparam int CNT_W = $clog2(PERIOD_CYCLES);

  // ----------------------------------------
  // Functions
  // ----------------------------------------

  // Field sign after polarity selection
  function automatic logic signed [16:0] mtmr_eff(input logic signed [15:0] amp, input logic inv);
    logic signed [16:0] ext;
    ext = {amp[15], amp};
    mtmr_eff = inv ? -ext : ext;
  endfunction

  // Byte-lane merge of a written word
  function automatic logic [31:0] mtmr_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    mtmr_merge = res;
  endfunction

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [CNT_W-1:0] cnt_reg;
  logic tick;
  logic pol_inv_reg;
  logic [15:0] track_thr_reg, mark_thr_reg, med_thr_reg, strong_thr_reg;
  logic signed [16:0] eff;
  logic [1:0] kind, str_code;
  logic [1:0] trk_n_reg, mk_n_reg, trk_base, mk_base;
  logic [1:0] trk_str_reg [0:1];
  logic signed [7:0] trk_x_reg [0:1];
  logic signed [7:0] trk_ang_reg [0:1];
  logic signed [7:0] mk_x_reg [0:1];
  logic signed [7:0] mk_y_reg [0:1];
  logic l_idx, r_idx;
  logic [1:0] nx_l_str, nx_r_str;
  logic signed [7:0] nx_l_x, nx_r_x, nx_l_ang, nx_r_ang, nx_ml_x, nx_mr_x, ref_x;
  logic nx_ml, nx_mr;
  logic [1:0] l_str_reg, r_str_reg;
  logic signed [7:0] l_x_reg, r_x_reg, l_ang_reg, r_ang_reg, ml_x_reg, mr_x_reg, pt_x_reg, pt_y_reg;
  logic ml_reg, mr_reg, pt_valid_reg;
  logic [15:0] period_cnt_reg;
  mtmr_pkg::mtmr_dec_type dec_state_reg;
  logic dec_side_reg;
  logic [15:0] dec_bits_reg, code_val_reg;
  logic [4:0] dec_cnt_reg, code_len_reg;
  logic code_done_reg;
  logic req, rd_clr;
  logic [31:0] rd_data;

  // ----------------------------------------
  // Evaluation period
  // ----------------------------------------

  assign tick = (cnt_reg == CNT_W'(PERIOD_CYCLES - 1));

  // Free-running period counter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
    end else if (tick) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + CNT_W'(1);
    end
  end

  // Tick out, aligned with published values
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      period_tick_o <= 1'b0;
      period_cnt_reg <= '0;
    end else begin
      period_tick_o <= tick;
      period_cnt_reg <= period_cnt_reg + {15'h0000, tick};
    end
  end

  // ----------------------------------------
  // Peak classification
  // ----------------------------------------

  assign eff = mtmr_eff(meas_amp_i, pol_inv_reg);

  // raised field is track, lowered is marker
  always_comb begin
    kind = mtmr_pkg::KIND_NONE;
    if (eff > $signed({1'b0, track_thr_reg})) begin
      kind = mtmr_pkg::KIND_TRACK;
    end else if (eff < -$signed({1'b0, mark_thr_reg})) begin
      kind = mtmr_pkg::KIND_MARK;
    end
  end

  // strength grading, never zero for a track
  always_comb begin
    if (eff >= $signed({1'b0, strong_thr_reg})) begin
      str_code = mtmr_pkg::STR_STRONG;
    end else if (eff >= $signed({1'b0, med_thr_reg})) begin
      str_code = mtmr_pkg::STR_MED;
    end else begin
      str_code = mtmr_pkg::STR_WEAK;
    end
  end

  // A peak arriving on the tick belongs to the new period
  assign trk_base = tick ? 2'h0 : trk_n_reg;
  assign mk_base = tick ? 2'h0 : mk_n_reg;

  // Collect up to two tracks and two markers per period; extras are dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trk_n_reg <= '0;
      mk_n_reg <= '0;
      for (int i = 0; i < 2; i++) begin
        trk_str_reg[i] <= '0;
        trk_x_reg[i] <= '0;
        trk_ang_reg[i] <= '0;
        mk_x_reg[i] <= '0;
        mk_y_reg[i] <= '0;
      end
    end else begin
      trk_n_reg <= trk_base;
      mk_n_reg <= mk_base;
      if (meas_valid_i && kind == mtmr_pkg::KIND_TRACK && trk_base < mtmr_pkg::SLOTS) begin
        trk_str_reg[trk_base[0]] <= str_code;
        trk_x_reg[trk_base[0]] <= meas_x_i;
        trk_ang_reg[trk_base[0]] <= meas_ang_i;
        trk_n_reg <= trk_base + 2'h1;
      end
      if (meas_valid_i && kind == mtmr_pkg::KIND_MARK && mk_base < mtmr_pkg::SLOTS) begin
        mk_x_reg[mk_base[0]] <= meas_x_i;
        mk_y_reg[mk_base[0]] <= meas_y_i;
        mk_n_reg <= mk_base + 2'h1;
      end
    end
  end

  // ----------------------------------------
  // Report assembly
  // ----------------------------------------

  // leftmost track goes to the left set
  assign l_idx = (trk_n_reg == 2'h2) && (trk_x_reg[1] < trk_x_reg[0]);
  assign r_idx = (trk_n_reg == 2'h2) ? ~l_idx : l_idx;

  // both sets always built; any track has position and angle
  always_comb begin
    nx_l_str = mtmr_pkg::STR_NONE;
    nx_r_str = mtmr_pkg::STR_NONE;
    nx_l_x = '0;
    nx_r_x = '0;
    nx_l_ang = '0;
    nx_r_ang = '0;
    if (trk_n_reg != 2'h0) begin
      nx_l_str = trk_str_reg[l_idx];
      nx_r_str = trk_str_reg[r_idx];
      nx_l_x = trk_x_reg[l_idx];
      nx_r_x = trk_x_reg[r_idx];
      nx_l_ang = trk_ang_reg[l_idx];
      nx_r_ang = trk_ang_reg[r_idx];
    end
  end

  // marker side against left track, or centre with no track
  always_comb begin
    ref_x = (trk_n_reg == 2'h0) ? 8'sh00 : trk_x_reg[l_idx];
    nx_ml = 1'b0;
    nx_mr = 1'b0;
    nx_ml_x = '0;
    nx_mr_x = '0;
    for (int i = 0; i < 2; i++) begin
      if (2'(i) < mk_n_reg) begin
        // first marker on each side gives its position
        if (mk_x_reg[i] < ref_x) begin
          if (!nx_ml) begin
            nx_ml_x = mk_x_reg[i];
          end
          nx_ml = 1'b1;
        end else begin
          if (!nx_mr) begin
            nx_mr_x = mk_x_reg[i];
          end
          nx_mr = 1'b1;
        end
      end
    end
  end

  // every published value changes on the same edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      l_str_reg <= mtmr_pkg::STR_NONE;
      r_str_reg <= mtmr_pkg::STR_NONE;
      l_x_reg <= '0;
      r_x_reg <= '0;
      l_ang_reg <= '0;
      r_ang_reg <= '0;
      ml_reg <= 1'b0;
      mr_reg <= 1'b0;
      ml_x_reg <= '0;
      mr_x_reg <= '0;
      pt_valid_reg <= 1'b0;
      pt_x_reg <= '0;
      pt_y_reg <= '0;
    end else if (tick) begin
      // signed mm; whole degrees per track
      l_str_reg <= nx_l_str;
      r_str_reg <= nx_r_str;
      l_x_reg <= nx_l_x;
      r_x_reg <= nx_r_x;
      l_ang_reg <= nx_l_ang;
      r_ang_reg <= nx_r_ang;
      ml_reg <= nx_ml;
      mr_reg <= nx_mr;
      ml_x_reg <= nx_ml_x;
      mr_x_reg <= nx_mr_x;
      // point source seen on the marker path, X and Y
      pt_valid_reg <= (mk_n_reg != 2'h0);
      pt_x_reg <= mk_x_reg[0];
      pt_y_reg <= mk_y_reg[0];
    end
  end

  // ----------------------------------------
  // Coded marker decoder
  // ----------------------------------------

  // One bit is a one-sided marker run (left 1, right 0) closed by a both-sided run
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dec_state_reg <= mtmr_pkg::DEC_IDLE;
      dec_side_reg <= 1'b0;
      dec_bits_reg <= '0;
      dec_cnt_reg <= '0;
      code_val_reg <= '0;
      code_len_reg <= '0;
      code_done_reg <= 1'b0;
    end else begin
      code_done_reg <= 1'b0;
      if (period_tick_o) begin
        case (dec_state_reg)
          mtmr_pkg::DEC_IDLE: begin
            if (ml_reg ^ mr_reg) begin
              dec_state_reg <= mtmr_pkg::DEC_SIDE;
              dec_side_reg <= ml_reg;
              dec_bits_reg <= '0;
              dec_cnt_reg <= '0;
            end else if (ml_reg & mr_reg) begin
              dec_state_reg <= mtmr_pkg::DEC_FAIL;
            end
          end
          mtmr_pkg::DEC_SIDE: begin
            if (ml_reg & mr_reg) begin
              // at most sixteen bits, shifted in order
              if (dec_cnt_reg == mtmr_pkg::CODE_MAX_BITS) begin
                dec_state_reg <= mtmr_pkg::DEC_FAIL;
              end else begin
                dec_state_reg <= mtmr_pkg::DEC_BOTH;
                dec_bits_reg <= {dec_bits_reg[14:0], dec_side_reg};
                dec_cnt_reg <= dec_cnt_reg + 5'h01;
              end
            end else if (!ml_reg && !mr_reg) begin
              dec_state_reg <= mtmr_pkg::DEC_IDLE;
            end else if (ml_reg != dec_side_reg) begin
              // side swap without a closing run
              dec_state_reg <= mtmr_pkg::DEC_FAIL;
            end
          end
          mtmr_pkg::DEC_BOTH: begin
            if (!ml_reg && !mr_reg) begin
              dec_state_reg <= mtmr_pkg::DEC_IDLE;
              code_val_reg <= dec_bits_reg;
              code_len_reg <= dec_cnt_reg;
              code_done_reg <= 1'b1;
            end else if (ml_reg ^ mr_reg) begin
              dec_state_reg <= mtmr_pkg::DEC_SIDE;
              dec_side_reg <= ml_reg;
            end
          end
          mtmr_pkg::DEC_FAIL: begin
            if (!ml_reg && !mr_reg) begin
              dec_state_reg <= mtmr_pkg::DEC_IDLE;
            end
          end
          default: begin
            dec_state_reg <= mtmr_pkg::DEC_IDLE;
          end
        endcase
      end
    end
  end

  // sticky flag, a new code wins over the read clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      code_avail_o <= 1'b0;
    end else begin
      code_avail_o <= code_done_reg | (code_avail_o & ~rd_clr);
    end
  end

  // ----------------------------------------
  // Wishbone slave
  // ----------------------------------------
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // reading the code word clears the flag
  assign rd_clr = req & ~wb_we_i & ({wb_adr_i[7:2], 2'b00} == mtmr_pkg::ADR_CODE);

  // Read mux; unmapped words read zero
  always_comb begin
    case ({wb_adr_i[7:2], 2'b00})
      mtmr_pkg::ADR_CTRL: rd_data = {31'h0, pol_inv_reg};
      mtmr_pkg::ADR_THR_DET: rd_data = {mark_thr_reg, track_thr_reg};
      mtmr_pkg::ADR_THR_STR: rd_data = {strong_thr_reg, med_thr_reg};
      mtmr_pkg::ADR_STATUS: rd_data = {period_cnt_reg, 8'h00, pt_valid_reg, mr_reg, ml_reg,
                                       r_str_reg, l_str_reg, code_avail_o};
      mtmr_pkg::ADR_TRACK_L: rd_data = {8'h00, l_ang_reg, l_x_reg, 6'h00, l_str_reg};
      mtmr_pkg::ADR_TRACK_R: rd_data = {8'h00, r_ang_reg, r_x_reg, 6'h00, r_str_reg};
      mtmr_pkg::ADR_MARKERS: rd_data = {8'h00, mr_x_reg, ml_x_reg, 6'h00, mr_reg, ml_reg};
      mtmr_pkg::ADR_POINT: rd_data = {15'h0000, pt_valid_reg, pt_y_reg, pt_x_reg};
      mtmr_pkg::ADR_CODE: rd_data = {11'h000, code_len_reg, code_val_reg};
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // One wait-free cycle: ack and data one edge after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= (req & ~wb_we_i) ? rd_data : 32'h0000_0000;
    end
  end

  // Writable configuration with byte lanes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pol_inv_reg <= mtmr_pkg::RST_POL_INV;
      track_thr_reg <= mtmr_pkg::RST_TRACK_THR;
      mark_thr_reg <= mtmr_pkg::RST_MARK_THR;
      med_thr_reg <= mtmr_pkg::RST_MED_THR;
      strong_thr_reg <= mtmr_pkg::RST_STRONG_THR;
    end else if (req & wb_we_i) begin
      case ({wb_adr_i[7:2], 2'b00})
        mtmr_pkg::ADR_CTRL: begin
          if (wb_sel_i[0]) begin
            pol_inv_reg <= wb_dat_i[0];
          end
        end
        mtmr_pkg::ADR_THR_DET: begin
          {mark_thr_reg, track_thr_reg} <= mtmr_merge({mark_thr_reg, track_thr_reg}, wb_dat_i, wb_sel_i);
        end
        mtmr_pkg::ADR_THR_STR: begin
          {strong_thr_reg, med_thr_reg} <= mtmr_merge({strong_thr_reg, med_thr_reg}, wb_dat_i, wb_sel_i);
        end
        default: begin
        end
      endcase
    end
  end

endmodule

// *** testbench.sv ***
// Self-checking testbench for the magnetic track measurement reporter
`timescale 1ns/1ns
module testbench;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, meas_valid_i, code_avail_o, period_tick_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic signed [15:0] meas_amp_i;
  logic signed [7:0] meas_x_i, meas_ang_i, meas_y_i;
  logic [1:0] seq [5] = '{2'b01, 2'b11, 2'b10, 2'b11, 2'b00};
  int fails = 0;
  int checks = 0;
  // Short period keeps the run small
  mtmr_reporter #(.PERIOD_CYCLES(64)) i_mtmr_reporter (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .meas_valid_i, .meas_amp_i, .meas_x_i, .meas_ang_i, .meas_y_i,
    .code_avail_o, .period_tick_o);
  mtmr_host i_mtmr_host (.clk_i, .wb_cyc_o(wb_cyc_i), .wb_stb_o(wb_stb_i), .wb_we_o(wb_we_i), .wb_adr_o(wb_adr_i),
    .wb_sel_o(wb_sel_i), .wb_dat_o(wb_dat_i), .wb_dat_i(wb_dat_o), .wb_ack_i(wb_ack_o));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Watchdog, far beyond the some 1000 cycles the tests need
  initial begin
    #200000;
    fails++;
    complete_run();
  end
  task automatic complete_run();
    $display("Checks %0d mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h got %h", n, e, g);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string n);
    i_mtmr_host.rd(a, q);
    chk(n, e, q);
  endtask
  // One field peak from the front end
  task automatic put(input logic [15:0] a, input logic [7:0] x, input logic [7:0] g, input logic [7:0] y);
    @(posedge clk_i);
    meas_valid_i <= 1'b1;
    meas_amp_i <= a;
    meas_x_i <= x;
    meas_ang_i <= g;
    meas_y_i <= y;
    @(posedge clk_i);
    meas_valid_i <= 1'b0;
  endtask
  // Bounded wait for the publishing tick
  task automatic wait_tick();
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (period_tick_o !== 1'b1 && n < 200);
    if (n >= 200) begin
      chk("tick", 32'h1, 32'h0);
    end
  endtask
  initial begin
    rst_i = 1'b1;
    meas_valid_i = 1'b0;
    meas_amp_i = 16'h0;
    meas_x_i = 8'h0;
    meas_ang_i = 8'h0;
    meas_y_i = 8'h0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(mtmr_pkg::ADR_CTRL, 32'h0, "ctrl");
    rdc(mtmr_pkg::ADR_THR_DET, 32'h01000100, "thr_det");
    rdc(mtmr_pkg::ADR_THR_STR, 32'h08000400, "thr_str");
    i_mtmr_host.wr(8'h24, 4'hf, 32'hffffffff);
    rdc(8'h24, 32'h0, "unmapped");
    i_mtmr_host.wr(mtmr_pkg::ADR_THR_STR, 4'h4, 32'h00aa0000);
    rdc(mtmr_pkg::ADR_THR_STR, 32'h08aa0400, "thr_lane");
    $display("Test registers done");
    put(16'h0200, 8'hfb, 8'h03, 8'h00);
    wait_tick();
    rdc(mtmr_pkg::ADR_TRACK_L, 32'h0003fb01, "one_l");
    rdc(mtmr_pkg::ADR_TRACK_R, 32'h0003fb01, "one_r");
    put(16'h0500, 8'h0a, 8'hfe, 8'h00);
    put(16'h0900, 8'hec, 8'h04, 8'h00);
    wait_tick();
    rdc(mtmr_pkg::ADR_TRACK_L, 32'h0004ec03, "two_l");
    i_mtmr_host.follow(1'b1, q);
    chk("two_r", 32'h00fe0a02, q);
    i_mtmr_host.rd(mtmr_pkg::ADR_STATUS, q);
    chk("status", 32'h16, {16'h0, q[15:0]});
    put(16'h0500, 8'h00, 8'h00, 8'h00);
    wait_tick();
    rdc(mtmr_pkg::ADR_TRACK_L, 32'h00000002, "back_l");
    rdc(mtmr_pkg::ADR_TRACK_R, 32'h00000002, "back_r");
    wait_tick();
    rdc(mtmr_pkg::ADR_TRACK_L, 32'h0, "none_l");
    $display("Test tracks done");
    put(16'h0200, 8'h00, 8'h00, 8'h00);
    put(16'hfe00, 8'he2, 8'h00, 8'h07);
    put(16'hfe00, 8'h19, 8'h00, 8'h09);
    wait_tick();
    rdc(mtmr_pkg::ADR_MARKERS, 32'h0019e203, "markers");
    rdc(mtmr_pkg::ADR_POINT, 32'h000107e2, "point");
    i_mtmr_host.wr(mtmr_pkg::ADR_CTRL, 4'hf, 32'h1);
    rdc(mtmr_pkg::ADR_CTRL, 32'h1, "ctrl_inv");
    put(16'hfe00, 8'h07, 8'h00, 8'h00);
    wait_tick();
    rdc(mtmr_pkg::ADR_TRACK_L, 32'h00000701, "inv_l");
    chk("reject", 32'h0, {31'h0, code_avail_o});
    i_mtmr_host.wr(mtmr_pkg::ADR_CTRL, 4'hf, 32'h0);
    $display("Test markers done");
    // two bit code 1 then 0
    for (int i = 0; i < 5; i++) begin
      if (seq[i][0]) begin
        put(16'hfe00, 8'he2, 8'h00, 8'h00);
      end
      if (seq[i][1]) begin
        put(16'hfe00, 8'h1e, 8'h00, 8'h00);
      end
      wait_tick();
    end
    repeat (3) @(posedge clk_i);
    chk("code_flag", 32'h1, {31'h0, code_avail_o});
    i_mtmr_host.fetch_code(code_avail_o, q);
    chk("code", 32'h00020002, q);
    @(posedge clk_i);
    chk("code_clr", 32'h0, {31'h0, code_avail_o});
    $display("Test code done");
    complete_run();
  end
endmodule
